//--- shared/tlp_pkg.sv
// Package with constants and carriers for the TLB lockdown placement block.
package tlp_pkg;

  // ----------------------------------------
  // Register encoding
  // ----------------------------------------
  localparam logic [3:0] CRN_LOCKDOWN = 4'hA;
  localparam logic [3:0] CRM_LOCKDOWN = 4'h0;
  localparam logic [2:0] OP1_LOCKDOWN = 3'h0;
  localparam logic [2:0] OP2_LOCKDOWN = 3'h0;
  localparam int SLOT_MSB = 29;
  localparam int SLOT_LSB = 28;
  localparam int PRESERVE_BIT = 0;
  localparam logic [1:0] SLOT_RESET = 2'h0;
  localparam logic PRESERVE_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int LOCK_SLOTS = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op1;
    logic [2:0] op2;
    logic [31:0] wdata;
  } tlp_xfer_t;

  typedef struct packed {
    logic privileged;
    logic nonSecure;
  } tlp_mode_t;

  typedef struct packed {
    logic toLockdown;
    logic [1:0] slot;
    logic [LOCK_SLOTS-1:0] slotOneHot;
  } tlp_place_t;

endpackage

//--- hw/tlp_lockdown.sv
// Lockdown control register and table walk placement steering.
`timescale 1ns/100ps

module tlp_lockdown (
  input wire logic clk,
  input wire logic rst,
  input wire tlp_pkg::tlp_xfer_t xfer,
  input wire tlp_pkg::tlp_mode_t mode,
  input wire logic nonsecureTlbLockdownPermit,
  input wire logic walkFill,
  output tlp_pkg::tlp_place_t place,
  output logic fillLockdown,
  output logic fillSetAssoc,
  output logic [31:0] rdata_q,
  output logic rdValid_q,
  output logic undefTrap_q
);

  // ----------------------------------------
  // Decode and permission
  // ----------------------------------------
  logic hit;
  logic allowed;
  logic [1:0] slot_q;
  logic preserve_q;
  logic [31:0] readWord;
  logic [tlp_pkg::LOCK_SLOTS-1:0] slotOneHot;

  // Decode keeps no state between requests, so back to back accesses need no stall.
  assign hit = xfer.valid && xfer.crn == tlp_pkg::CRN_LOCKDOWN
    && xfer.crm == tlp_pkg::CRM_LOCKDOWN && xfer.op1 == tlp_pkg::OP1_LOCKDOWN
    && xfer.op2 == tlp_pkg::OP2_LOCKDOWN;
  // Security state only gates access; the state itself selects no copy.
  assign allowed = mode.privileged
    && (!mode.nonSecure || nonsecureTlbLockdownPermit);

  // ----------------------------------------
  // Register
  // ----------------------------------------
  // Only a permitted write touches the register; a refused one leaves both fields alone.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slot_q <= tlp_pkg::SLOT_RESET;
      preserve_q <= tlp_pkg::PRESERVE_RESET;
    end
    else if (hit && xfer.write && allowed)
    begin
      slot_q <= xfer.wdata[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB];
      preserve_q <= xfer.wdata[tlp_pkg::PRESERVE_BIT];
    end
  end

  // Reserved fields read as zero, which keeps read-modify-write sequences clean.
  always_comb
  begin
    readWord = 32'h0000_0000;
    readWord[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB] = slot_q;
    readWord[tlp_pkg::PRESERVE_BIT] = preserve_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= tlp_pkg::RDATA_RESET;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= hit && !xfer.write && allowed;
      if (hit && !xfer.write && allowed)
        rdata_q <= readWord;
    end
  end

  // The trap answers in the cycle a read answer would, so the core sees one latency.
  always_ff @(posedge clk)
  begin
    if (rst)
      undefTrap_q <= 1'b0;
    else
      undefTrap_q <= hit && !allowed;
  end

  // ----------------------------------------
  // Placement
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < tlp_pkg::LOCK_SLOTS; i++)
    begin : g_slot
      assign slotOneHot[i] = preserve_q && slot_q == 2'(i);
    end
  endgenerate

  // The decoded slot travels beside the raw field so the fill path needs no decoder.
  always_comb
  begin
    place.toLockdown = preserve_q;
    place.slot = slot_q;
    place.slotOneHot = slotOneHot;
  end

  // A fill follows the register at once; a write lands before the next walk sees it.
  assign fillLockdown = walkFill && preserve_q;
  assign fillSetAssoc = walkFill && !preserve_q;

  // ----------------------------------------
  // Access checks
  // ----------------------------------------
  a_refused_no_write: assert property (@(posedge clk) disable iff (rst)
    hit && !allowed |=> $stable(slot_q) && $stable(preserve_q) && undefTrap_q)
    else $error("Refused access changed the register or raised no trap.");
  a_user_refused: assert property (@(posedge clk) disable iff (rst)
    hit && !mode.privileged |=> undefTrap_q && !rdValid_q)
    else $error("User mode access was not refused.");
  a_ns_permit: assert property (@(posedge clk) disable iff (rst)
    hit && mode.nonSecure && !nonsecureTlbLockdownPermit |=> undefTrap_q)
    else $error("Non-secure access without permit was not refused.");
  a_user_no_write: assert property (@(posedge clk) disable iff (rst)
    hit && !mode.privileged |=> $stable(slot_q) && $stable(preserve_q))
    else $error("User mode access changed the register.");
  a_no_read_refused: assert property (@(posedge clk) disable iff (rst)
    hit && !allowed |=> !rdValid_q)
    else $error("Refused access returned read data.");
  a_trap_needs_hit: assert property (@(posedge clk) disable iff (rst)
    !(hit && !allowed) |=> !undefTrap_q)
    else $error("Trap raised without a refused access.");
  a_secure_allowed: assert property (@(posedge clk) disable iff (rst)
    hit && mode.privileged && !mode.nonSecure |=> !undefTrap_q)
    else $error("Privileged Secure access was refused.");
  a_ns_permitted: assert property (@(posedge clk) disable iff (rst)
    hit && mode.privileged && mode.nonSecure && nonsecureTlbLockdownPermit |=> !undefTrap_q)
    else $error("Permitted Non-secure access was refused.");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  // A Non-secure write must read back from Secure state, as there is no banked copy.
  a_shared_copy: assert property (@(posedge clk) disable iff (rst)
    hit && xfer.write && allowed && mode.nonSecure ##1 !(hit && xfer.write)
    ##1 hit && !xfer.write && allowed && !mode.nonSecure
    |=> rdata_q[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB]
      == $past(xfer.wdata[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB], 3)
      && rdata_q[tlp_pkg::PRESERVE_BIT] == $past(xfer.wdata[tlp_pkg::PRESERVE_BIT], 3))
    else $error("Secure read did not return the Non-secure write.");
  a_write_takes: assert property (@(posedge clk) disable iff (rst)
    hit && xfer.write && allowed |=> preserve_q == $past(xfer.wdata[0]))
    else $error("Permitted write did not update the preserve flag.");
  a_write_slot: assert property (@(posedge clk) disable iff (rst)
    hit && xfer.write && allowed
    |=> slot_q == $past(xfer.wdata[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB]))
    else $error("Permitted write did not update the slot field.");
  a_hold_unwritten: assert property (@(posedge clk) disable iff (rst)
    !(hit && xfer.write && allowed) |=> $stable(slot_q) && $stable(preserve_q))
    else $error("Register changed without a permitted write.");
  a_write_no_answer: assert property (@(posedge clk) disable iff (rst)
    hit && xfer.write |=> !rdValid_q)
    else $error("Write produced a read answer.");

  // ----------------------------------------
  // Read checks
  // ----------------------------------------
  a_read_value: assert property (@(posedge clk) disable iff (rst)
    hit && !xfer.write && allowed |=> rdValid_q && rdata_q[0] == $past(preserve_q))
    else $error("Read did not return the preserve flag.");
  a_read_slot: assert property (@(posedge clk) disable iff (rst)
    hit && !xfer.write && allowed
    |=> rdata_q[tlp_pkg::SLOT_MSB:tlp_pkg::SLOT_LSB] == $past(slot_q))
    else $error("Read did not return the slot field.");
  a_read_reserved: assert property (@(posedge clk) disable iff (rst)
    rdValid_q |-> rdata_q[31:tlp_pkg::SLOT_MSB+1] == '0
      && rdata_q[tlp_pkg::SLOT_LSB-1:tlp_pkg::PRESERVE_BIT+1] == '0)
    else $error("Reserved read bits were not zero.");
  a_rdata_holds: assert property (@(posedge clk) disable iff (rst)
    !(hit && !xfer.write && allowed) |=> $stable(rdata_q))
    else $error("Read data changed without a permitted read.");
  a_read_needs_hit: assert property (@(posedge clk) disable iff (rst)
    !(hit && !xfer.write && allowed) |=> !rdValid_q)
    else $error("Read answer without a permitted read.");
  a_answer_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(rdValid_q && undefTrap_q))
    else $error("Read answer and trap raised together.");

  // ----------------------------------------
  // Placement checks
  // ----------------------------------------
  a_lock_slot: assert property (@(posedge clk) disable iff (rst)
    walkFill && preserve_q |-> fillLockdown && place.slotOneHot[slot_q] && !fillSetAssoc)
    else $error("Walk fill did not target the selected lockdown slot.");
  a_setassoc: assert property (@(posedge clk) disable iff (rst)
    walkFill && !preserve_q |-> fillSetAssoc && !fillLockdown && place.slotOneHot == 4'h0)
    else $error("Walk fill went to the lockdown region with preserve clear.");
  a_one_slot: assert property (@(posedge clk) disable iff (rst)
    $countones(place.slotOneHot) == int'(preserve_q))
    else $error("Lockdown slot selection is not one-hot while preserving.");
  a_slot_follows: assert property (@(posedge clk) disable iff (rst)
    preserve_q |-> place.slotOneHot == (4'h1 << place.slot) && place.toLockdown)
    else $error("Lockdown slot does not follow the slot field.");
  a_onehot_idle: assert property (@(posedge clk) disable iff (rst)
    !preserve_q |-> place.slotOneHot == 4'h0 && !place.toLockdown)
    else $error("Lockdown slot selected with preserve clear.");
  a_one_region: assert property (@(posedge clk) disable iff (rst)
    walkFill |-> fillLockdown != fillSetAssoc)
    else $error("Walk fill did not pick exactly one region.");
  a_idle_no_fill: assert property (@(posedge clk) disable iff (rst)
    !walkFill |-> !fillLockdown && !fillSetAssoc)
    else $error("Fill raised without a table walk.");

  // ----------------------------------------
  // Reset checks
  // ----------------------------------------
  // No disable here, so the state seen on the first edge after release is checked too.
  a_reset_clear: assert property (@(posedge clk)
    rst |=> slot_q == tlp_pkg::SLOT_RESET && preserve_q == tlp_pkg::PRESERVE_RESET
      && rdata_q == tlp_pkg::RDATA_RESET && !rdValid_q && !undefTrap_q)
    else $error("Reset left the register or the answers set.");

endmodule

//--- test/tlp_lockdown_tb_top.sv
// Self-checking testbench for the lockdown control register and walk steering.
`timescale 1ns/100ps
module tlp_lockdown_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tlp_pkg::tlp_xfer_t xf = '0;
  tlp_pkg::tlp_mode_t md = '0;
  logic pm = 1'b0;
  logic wf = 1'b0;
  tlp_pkg::tlp_place_t pl;
  logic fl, fs, rv, ut;
  logic [31:0] rd;
  int mismatches = 0;
  int checksDone = 0;
  always #12.5 clk = ~clk;
  tlp_lockdown dut (.clk(clk), .rst(rst), .xfer(xf), .mode(md),
    .nonsecureTlbLockdownPermit(pm), .walkFill(wf), .place(pl), .fillLockdown(fl),
    .fillSetAssoc(fs), .rdata_q(rd), .rdValid_q(rv), .undefTrap_q(ut));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Returns one settle step after the taking edge, where the answer pulses stand.
  task acc(input logic w, input logic p, input logic n, input logic [31:0] d);
    @(posedge clk);
    xf <= tlp_pkg::tlp_xfer_t'{1'b1, w, tlp_pkg::CRN_LOCKDOWN, tlp_pkg::CRM_LOCKDOWN,
      tlp_pkg::OP1_LOCKDOWN, tlp_pkg::OP2_LOCKDOWN, d};
    md <= tlp_pkg::tlp_mode_t'{p, n};
    @(posedge clk);
    xf.valid <= 1'b0;
    #1;
  endtask
  task summarize;
    $display("mismatches %0d checksDone %0d", mismatches, checksDone);
    if (mismatches == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_lock;
    chk("setassoc", 1, fs);
    acc(1, 1, 0, 32'hFFFF_FFFF);
    chk("fillLock", 1, fl);
    chk("onehot", 32'h0000_0008, pl.slotOneHot);
    acc(0, 1, 0, 0);
    chk("rdValid", 1, rv);
    chk("rdata", 32'h3000_0001, rd);
  endtask
  task t_user;
    acc(1, 0, 0, 0);
    chk("trapUser", 1, ut);
    acc(0, 1, 0, 0);
    chk("keep", 32'h3000_0001, rd);
  endtask
  // Non-secure write is seen from Secure state: one shared copy.
  task t_ns;
    @(posedge clk);
    pm <= 1'b0;
    acc(1, 1, 1, 0);
    chk("trapNs", 1, ut);
    chk("noRd", 0, rv);
    acc(0, 1, 1, 0);
    chk("trapNsRd", 1, ut);
    chk("noRdNs", 0, rv);
    acc(0, 1, 0, 0);
    chk("keepNs", 32'h3000_0001, rd);
    @(posedge clk);
    pm <= 1'b1;
    acc(1, 1, 1, 32'h1000_0000);
    chk("noTrap", 0, ut);
    acc(0, 1, 0, 0);
    chk("shared", 32'h1000_0000, rd);
    chk("fillSa", 1, fs);
    chk("noLock", 0, fl);
  endtask
  task t_slots;
    for (int i = 0; i < 4; i++)
    begin
      acc(1, 1, 0, {2'h0, i[1:0], 27'h0, 1'b1});
      chk("slot", 32'h0000_0001 << i, pl.slotOneHot);
      chk("slotField", i, pl.slot);
      chk("toLock", 1, pl.toLockdown);
    end
  endtask
  // With preserve set, no fill may show while no walk is running.
  task t_idle;
    @(posedge clk);
    wf <= 1'b0;
    @(posedge clk);
    #1;
    chk("idleLock", 0, fl);
    chk("idleSa", 0, fs);
    @(posedge clk);
    wf <= 1'b1;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wf <= 1'b1;
    acc(0, 1, 0, 0);
    chk("rstVal", 0, rd);
    t_lock();
    t_user();
    t_ns();
    t_slots();
    t_idle();
    summarize();
  end
  // The whole run is under 100 cycles, so this limit only trips on a hang.
  initial
  begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule
